//--- common/esm_ctrl_params.svh
// Constants for the error-signal routing and life-cycle controller.
// Assumes inclusion by bare name from any file that needs it.
`ifndef ESM_CTRL_PARAMS_SVH
`define ESM_CTRL_PARAMS_SVH

// Clock and millisecond tick
`define CLK_PERIOD_NS    40
`define MS_PERIOD_NS     1000000
// Sequence timeout after power-on, in ms
`define SEQ_TIMEOUT_MS   10

// Error delay code bands, their base times in ms and their step shifts (steps of 2 and 4 ms)
`define DLY_BAND1_CODE   8'h20
`define DLY_BAND2_CODE   8'h40
`define DLY_BAND0_BASE   10'h001
`define DLY_BAND1_BASE   10'h022
`define DLY_BAND2_BASE   10'h064
`define DLY_BAND1_SHIFT  1
`define DLY_BAND2_SHIFT  2

// Fuse word check masks for a 13-bit SEC-DED code over 8 data bits
`define ECC_MASK_S0      13'h0AAA
`define ECC_MASK_S1      13'h0CCC
`define ECC_MASK_S2      13'h10F0
`define ECC_MASK_S3      13'h1F00
`define ECC_WORD_W       13
`define ECC_NONE         4'h0

// Self-test run-at-power-up enable value
`define SELF_TEST_AT_POWERUP_RUN       1'b1

`endif

//--- common/esm_ctrl_pkg.sv
// Types for the error-signal routing and life-cycle controller.
// Assumes the constants header is compiled alongside.
package esm_ctrl_pkg;

  // Device life cycle
  typedef enum logic [2:0] {
    OFF,
    SELF_TEST,
    CFG_LOAD,
    ACTIVE,
    LATCHED_FAULT_STATE
  } life_e;

  // Error-signal mapping and delay configuration
  typedef struct packed {
    logic       mapToWdo;
    logic       mapToIrq;
    logic       mapToRst;
    logic [7:0] delayCode;
  } err_cfg_s;

  // Causes that force the latched fault state
  typedef struct packed {
    logic thermalShutdown;
    logic addressPinFault;
  } hard_fault_s;

endpackage

//--- rtl/esm_fault_ctrl.sv
// Error-signal routing to the three active-low fault outputs, plus the
// device life cycle (self-test, fuse load, active, latched fault state).
// Assumes rst is the power-on reset, pins are asynchronous, and all
// configuration and host strobes come from logic on clk_sys.
`timescale 1ns/1ps
`include "esm_ctrl_params.svh"

module esm_fault_ctrl #(
  parameter int MS_CYCLES      = `MS_PERIOD_NS / `CLK_PERIOD_NS,
  parameter int SEQ_TIMEOUT_MS = `SEQ_TIMEOUT_MS
) (
  input  wire logic                      clk_sys,
  input  wire logic                      rst,
  input  wire logic                      errorSignalInput,
  input  wire logic                      watchdogEnablePin,
  input  wire esm_ctrl_pkg::err_cfg_s    errCfg,
  input  wire logic [7:0]                resetHoldDelay,
  input  wire logic                      clearErrorFlag,
  input  wire logic                      selfTestAtPowerup,
  input  wire logic                      selfTestTrigger,
  input  wire logic                      selfTestDoneEnable,
  input  wire logic                      clearSelfTestFlag,
  input  wire logic                      selfTestDone,
  input  wire logic                      selfTestPass,
  input  wire logic                      fuseWordValid,
  input  wire logic [`ECC_WORD_W-1:0]    fuseWord,
  input  wire logic                      fuseLast,
  input  wire esm_ctrl_pkg::hard_fault_s hardFault,
  output logic                           watchdogFaultOutputN,
  output logic                           interruptOutputN,
  output logic                           resetOutputN,
  output logic                           errorSignalFaultFlag,
  output logic                           selfTestDoneFlag,
  output logic                           selfTestDoneStatus,
  output esm_ctrl_pkg::life_e            monitorStateRegister,
  output logic                           selfTestStart,
  output logic                           hostPortEnable,
  output logic                           uvFaultMask,
  output logic [7:0]                     configByte,
  output logic                           configByteValid,
  output logic                           doubleErrorDetect
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Error delay in ms from the 8-bit code
  function automatic logic [9:0] errDelayMs(input logic [7:0] code);
    logic [9:0] c;
    c = {2'h0, code};
    if (code < `DLY_BAND1_CODE) begin
      errDelayMs = `DLY_BAND0_BASE + c;
    end else if (code < `DLY_BAND2_CODE) begin
      errDelayMs = `DLY_BAND1_BASE + ((c - {2'h0, `DLY_BAND1_CODE}) << `DLY_BAND1_SHIFT);
    end else begin
      errDelayMs = `DLY_BAND2_BASE + ((c - {2'h0, `DLY_BAND2_CODE}) << `DLY_BAND2_SHIFT);
    end
  endfunction

  // SEC-DED decode: {double error, corrected data byte}
  function automatic logic [8:0] eccDecode(input logic [`ECC_WORD_W-1:0] w);
    logic [3:0]             s;
    logic                   p;
    logic                   ded;
    logic [`ECC_WORD_W-1:0] c;
    s = {^(w & `ECC_MASK_S3), ^(w & `ECC_MASK_S2), ^(w & `ECC_MASK_S1), ^(w & `ECC_MASK_S0)};
    p = ^w;
    c = w;
    ded = 1'b0;
    if (s != `ECC_NONE && p) begin
      if (s < 4'(`ECC_WORD_W)) begin
        c[s] = ~c[s];
      end else begin
        ded = 1'b1;
      end
    end else if (s != `ECC_NONE) begin
      ded = 1'b1;
    end
    eccDecode = {ded, c[12:9], c[7:5], c[3]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic errMeta_q;
  logic errSync_q;
  logic wdeMeta_q;
  logic wdeSync_q;

  // Two flops per asynchronous pin; error pin resets to low like its pull-down
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      errMeta_q <= 1'b0;
      errSync_q <= 1'b0;
      wdeMeta_q <= 1'b0;
      wdeSync_q <= 1'b0;
    end else begin
      errMeta_q <= errorSignalInput;
      errSync_q <= errMeta_q;
      wdeMeta_q <= watchdogEnablePin;
      wdeSync_q <= wdeMeta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Millisecond tick and sequence timer

  logic [31:0] msCnt_q;
  logic [31:0] msCnt_d;
  logic [31:0] seqMs_q;
  logic [31:0] seqMs_d;
  logic        msTick;
  logic        uvMask_q;
  logic        uvMask_d;

  // Free-running divider; sequence timer from power-on masks undervoltage
  always_comb begin
    msTick   = (msCnt_q == 32'(MS_CYCLES - 1));
    msCnt_d  = msTick ? 32'h0000_0000 : msCnt_q + 32'h0000_0001;
    seqMs_d  = seqMs_q;
    uvMask_d = uvMask_q;
    if (uvMask_q && msTick) begin
      seqMs_d = seqMs_q + 32'h0000_0001;
      if (seqMs_d >= 32'(SEQ_TIMEOUT_MS)) begin
        uvMask_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      msCnt_q  <= 32'h0000_0000;
      seqMs_q  <= 32'h0000_0000;
      uvMask_q <= 1'b1;
    end else begin
      msCnt_q  <= msCnt_d;
      seqMs_q  <= seqMs_d;
      uvMask_q <= uvMask_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Life cycle

  esm_ctrl_pkg::life_e state_q;
  esm_ctrl_pkg::life_e state_d;
  logic                stDone_q;
  logic                stDone_d;
  logic                stStat_q;
  logic                stStat_d;
  logic                start_q;
  logic                start_d;
  logic [7:0]          cfgByte_q;
  logic [7:0]          cfgByte_d;
  logic                cfgValid_q;
  logic                cfgValid_d;
  logic                ded_q;
  logic                ded_d;
  logic [8:0]          dec;

  // Power-on sequencing, self-test, fuse load and the latched fault state
  always_comb begin
    state_d    = state_q;
    stDone_d   = stDone_q;
    stStat_d   = stStat_q;
    start_d    = 1'b0;
    cfgByte_d  = cfgByte_q;
    cfgValid_d = 1'b0;
    ded_d      = ded_q;
    dec        = eccDecode(fuseWord);
    if (clearSelfTestFlag) begin
      stDone_d = 1'b0;
    end
    case (state_q)
      esm_ctrl_pkg::OFF: begin
        // Power-up strap taken once after reset release
        if (selfTestAtPowerup == `SELF_TEST_AT_POWERUP_RUN) begin
          state_d = esm_ctrl_pkg::SELF_TEST;
          start_d = 1'b1;
        end else begin
          state_d = esm_ctrl_pkg::CFG_LOAD;
        end
      end
      esm_ctrl_pkg::SELF_TEST: begin
        if (selfTestDone) begin
          stDone_d = 1'b1;
          stStat_d = 1'b1;
          state_d  = selfTestPass ? esm_ctrl_pkg::CFG_LOAD : esm_ctrl_pkg::LATCHED_FAULT_STATE;
        end
      end
      esm_ctrl_pkg::CFG_LOAD: begin
        if (fuseWordValid) begin
          cfgByte_d  = dec[7:0];
          cfgValid_d = 1'b1;
          if (dec[8]) begin
            ded_d   = 1'b1;
            state_d = esm_ctrl_pkg::LATCHED_FAULT_STATE;
          end else if (fuseLast) begin
            state_d = esm_ctrl_pkg::ACTIVE;
          end
        end
      end
      esm_ctrl_pkg::ACTIVE: begin
        if (selfTestTrigger) begin
          state_d  = esm_ctrl_pkg::SELF_TEST;
          start_d  = 1'b1;
          stStat_d = 1'b0;
        end
      end
      default: begin
        state_d = esm_ctrl_pkg::LATCHED_FAULT_STATE;
      end
    endcase
    if (hardFault != '0 && state_q != esm_ctrl_pkg::OFF) begin
      state_d = esm_ctrl_pkg::LATCHED_FAULT_STATE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q    <= esm_ctrl_pkg::OFF;
      stDone_q   <= 1'b0;
      stStat_q   <= 1'b0;
      start_q    <= 1'b0;
      cfgByte_q  <= 8'h00;
      cfgValid_q <= 1'b0;
      ded_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      stDone_q   <= stDone_d;
      stStat_q   <= stStat_d;
      start_q    <= start_d;
      cfgByte_q  <= cfgByte_d;
      cfgValid_q <= cfgValid_d;
      ded_q      <= ded_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error-signal routing

  logic       active;
  logic       latched_fault_state;
  logic       wdoGate;
  logic       examine;
  logic       errEvent;
  logic [9:0] errMs_q;
  logic [9:0] errMs_d;
  logic [7:0] rstMs_q;
  logic [7:0] rstMs_d;
  logic       rstPulse_q;
  logic       rstPulse_d;
  logic       flag_q;
  logic       flag_d;
  logic       irqLat_q;
  logic       irqLat_d;
  logic       wdoLat_q;
  logic       wdoLat_d;

  // Delay count, latches, reset pulse; set wins over a same-cycle clear
  always_comb begin
    active   = (state_q == esm_ctrl_pkg::ACTIVE);
    latched_fault_state = (state_q == esm_ctrl_pkg::LATCHED_FAULT_STATE);
    wdoGate  = errCfg.mapToWdo && errCfg.mapToRst && wdeSync_q && wdoLat_q;
    examine  = active && !rstPulse_q && !wdoGate;
    errMs_d  = errMs_q;
    errEvent = 1'b0;
    if (!examine || errSync_q) begin
      errMs_d = 10'h000;
    end else if (msTick) begin
      errMs_d = errMs_q + 10'h001;
      if (errMs_d >= errDelayMs(errCfg.delayCode)) begin
        errEvent = 1'b1;
        errMs_d  = 10'h000;
      end
    end
    flag_d     = flag_q && !clearErrorFlag;
    irqLat_d   = irqLat_q && !clearErrorFlag;
    wdoLat_d   = wdoLat_q && !clearErrorFlag && wdeSync_q;
    rstPulse_d = rstPulse_q;
    rstMs_d    = rstMs_q;
    if (rstPulse_q && msTick) begin
      rstMs_d = rstMs_q + 8'h01;
      if (rstMs_d >= resetHoldDelay) begin
        rstPulse_d = 1'b0;
        rstMs_d    = 8'h00;
      end
    end
    if (errEvent) begin
      flag_d = 1'b1;
      if (errCfg.mapToIrq) begin
        irqLat_d = 1'b1;
      end
      if (errCfg.mapToWdo && wdeSync_q) begin
        wdoLat_d = 1'b1;
      end
      if (errCfg.mapToRst) begin
        rstPulse_d = 1'b1;
        rstMs_d    = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      errMs_q    <= 10'h000;
      rstMs_q    <= 8'h00;
      rstPulse_q <= 1'b0;
      flag_q     <= 1'b0;
      irqLat_q   <= 1'b0;
      wdoLat_q   <= 1'b0;
    end else begin
      errMs_q    <= errMs_d;
      rstMs_q    <= rstMs_d;
      rstPulse_q <= rstPulse_d;
      flag_q     <= flag_d;
      irqLat_q   <= irqLat_d;
      wdoLat_q   <= wdoLat_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Fault pins low when asserted; latched fault state pulls reset and interrupt
  assign watchdogFaultOutputN = !wdoLat_q;
  assign interruptOutputN     = !(irqLat_q || latched_fault_state || (stDone_q && selfTestDoneEnable));
  assign resetOutputN         = !(rstPulse_q || latched_fault_state || !active);
  assign errorSignalFaultFlag = flag_q;
  assign selfTestDoneFlag     = stDone_q;
  assign selfTestDoneStatus   = stStat_q;
  assign monitorStateRegister = state_q;
  assign selfTestStart        = start_q;
  assign hostPortEnable       = (state_q != esm_ctrl_pkg::SELF_TEST) && (state_q != esm_ctrl_pkg::OFF);
  assign uvFaultMask          = uvMask_q;
  assign configByte           = cfgByte_q;
  assign configByteValid      = cfgValid_q;
  assign doubleErrorDetect    = ded_q;

endmodule

//--- verif/esm_fault_ctrl_properties.sv
// Checker for the error-signal routing and life-cycle controller.
// Assumes the design package is compiled first; bound to the top module.
`timescale 1ns/1ps
module esm_fault_ctrl_checker (
  input wire logic                   clk_sys,
  input wire logic                   rst,
  input wire logic                   watchdogFaultOutputN,
  input wire logic                   interruptOutputN,
  input wire logic                   resetOutputN,
  input wire logic                   errorSignalFaultFlag,
  input wire logic                   selfTestDoneFlag,
  input wire logic                   selfTestDoneStatus,
  input wire logic                   selfTestDoneEnable,
  input wire logic                   selfTestDone,
  input wire logic                   selfTestPass,
  input wire logic                   selfTestStart,
  input wire logic                   hostPortEnable,
  input wire logic                   clearErrorFlag,
  input wire logic                   clearSelfTestFlag,
  input wire esm_ctrl_pkg::err_cfg_s errCfg,
  input wire esm_ctrl_pkg::life_e    monitorStateRegister
);
  esm_ctrl_pkg::life_e st;
  assign st = monitorStateRegister;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // Life cycle
  property p_fs_outs; st == esm_ctrl_pkg::LATCHED_FAULT_STATE |-> !resetOutputN && !interruptOutputN; endproperty
  a_fs_outs: assert property (p_fs_outs) else $error("fault state outputs not low");
  property p_fs_stay; st == esm_ctrl_pkg::LATCHED_FAULT_STATE |=> st == esm_ctrl_pkg::LATCHED_FAULT_STATE; endproperty
  a_fs_stay: assert property (p_fs_stay) else $error("fault state left");
  property p_rst_low; st != esm_ctrl_pkg::ACTIVE |-> !resetOutputN; endproperty
  a_rst_low: assert property (p_rst_low) else $error("reset released before active");
  property p_st_start; $rose(st == esm_ctrl_pkg::SELF_TEST) |-> selfTestStart ##1 !selfTestStart; endproperty
  a_st_start: assert property (p_st_start) else $error("self-test not started");
  property p_host; hostPortEnable == !(st inside {esm_ctrl_pkg::OFF, esm_ctrl_pkg::SELF_TEST}); endproperty
  a_host: assert property (p_host) else $error("host port enable wrong");
  property p_done;
    selfTestDone && selfTestPass && st == esm_ctrl_pkg::SELF_TEST
      |=> selfTestDoneFlag && selfTestDoneStatus && st == esm_ctrl_pkg::CFG_LOAD;
  endproperty
  a_done: assert property (p_done) else $error("self-test completion not reported");
  // Error routing
  property p_wdo_cause; $fell(watchdogFaultOutputN) |-> errCfg.mapToWdo && errorSignalFaultFlag; endproperty
  a_wdo_cause: assert property (p_wdo_cause) else $error("watchdog output without cause");
  property p_irq_map;
    $rose(errorSignalFaultFlag) && st == esm_ctrl_pkg::ACTIVE && !(selfTestDoneFlag && selfTestDoneEnable)
      |-> interruptOutputN == !errCfg.mapToIrq;
  endproperty
  a_irq_map: assert property (p_irq_map) else $error("interrupt routing wrong");
  property p_irq_hold;
    $rose(interruptOutputN) && st == esm_ctrl_pkg::ACTIVE && $past(st) == esm_ctrl_pkg::ACTIVE
      |-> $past(clearErrorFlag) || $past(clearSelfTestFlag);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt released without clear");
  c_fs: cover property (st == esm_ctrl_pkg::LATCHED_FAULT_STATE);
  c_rpulse: cover property (st == esm_ctrl_pkg::ACTIVE && $fell(resetOutputN));
  c_wdo: cover property ($fell(watchdogFaultOutputN));
endmodule
bind esm_fault_ctrl esm_fault_ctrl_checker i_esm_fault_ctrl_checker (.*);

//--- verif/soc_model.sv
// Model of the monitored processor driving the error pin.
// Assumes its reset input is the controller's reset output.
`timescale 1ns/1ps
module soc_model (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic resetOutputN,
  input  wire logic errorCmd,
  input  wire logic stuckLow,
  output logic      errorSignalInput
);
  logic wasReset_q;
  // A reset processor restarts with its error pin high, unless stuck
  always_ff @(posedge clk_sys) begin
    if (rst || !errorCmd) wasReset_q <= 1'h0;
    else if (!resetOutputN && !stuckLow) wasReset_q <= 1'h1;
  end
  // Error pin is active low
  assign errorSignalInput = !(errorCmd && !wasReset_q);
endmodule

//--- verif/esm_fault_ctrl_tb.sv
// Self-checking bench for the error-signal routing and life-cycle block.
// Assumes package, checker and processor model are compiled first.
`timescale 1ns/1ps
`include "esm_ctrl_params.svh"
module esm_fault_ctrl_tb;
  localparam int MS = 4;
  logic        clk_sys = 1'h0, rst = 1'h1, watchdogEnablePin = 1'h0, clearErrorFlag = 1'h0;
  logic        selfTestAtPowerup = 1'h1, selfTestTrigger = 1'h0, selfTestDoneEnable = 1'h1;
  logic        clearSelfTestFlag = 1'h0, selfTestDone = 1'h0, selfTestPass = 1'h0;
  logic        fuseWordValid = 1'h0, fuseLast = 1'h0, errorCmd = 1'h0, stuckLow = 1'h0;
  logic [7:0]  resetHoldDelay = 8'h01, configByte;
  logic [12:0] fuseWord = 13'h0000;
  logic        errorSignalInput, watchdogFaultOutputN, interruptOutputN, resetOutputN;
  logic        errorSignalFaultFlag, selfTestDoneFlag, selfTestDoneStatus, selfTestStart;
  logic        hostPortEnable, uvFaultMask, configByteValid, doubleErrorDetect;
  esm_ctrl_pkg::err_cfg_s    errCfg = '0;
  esm_ctrl_pkg::hard_fault_s hardFault = '0;
  esm_ctrl_pkg::life_e       monitorStateRegister;
  int          nErrors = 0, numChecks = 0;
  esm_fault_ctrl #(.MS_CYCLES(MS), .SEQ_TIMEOUT_MS(2)) i_esm_fault_ctrl (.*);
  soc_model i_soc_model (.*);
  always #20 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  // Compare and report
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stopTest();
    if (nErrors == 0 && numChecks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Bounded wait for a life-cycle state
  task automatic waitState(input esm_ctrl_pkg::life_e s);
    for (int i = 0; i < 16; i++) begin
      if (monitorStateRegister === s) return;
      @(posedge clk_sys);
      #1;
    end
    chk("state", monitorStateRegister, s);
    stopTest();
  endtask
  // One-cycle host strobes
  task automatic hostPulse(input logic ce, input logic cs, input logic tr);
    @(posedge clk_sys);
    {clearErrorFlag, clearSelfTestFlag, selfTestTrigger} <= {ce, cs, tr};
    @(posedge clk_sys);
    {clearErrorFlag, clearSelfTestFlag, selfTestTrigger} <= 3'h0;
    #1;
  endtask
  // Fuse word with even check groups and even overall parity
  function automatic logic [12:0] enc(input logic [7:0] d);
    logic [12:0] w;
    w = 13'h0000;
    {w[12], w[11], w[10], w[9], w[7], w[6], w[5], w[3]} = d;
    w[1] = ^(w & `ECC_MASK_S0);
    w[2] = ^(w & `ECC_MASK_S1);
    w[4] = ^(w & `ECC_MASK_S2);
    w[8] = ^(w & `ECC_MASK_S3);
    w[0] = ^w[12:1];
    return w;
  endfunction
  task automatic fuse(input logic [12:0] w, input logic last, input logic [7:0] exp, input logic dbl);
    @(posedge clk_sys);
    {fuseWordValid, fuseWord, fuseLast} <= {1'h1, w, last};
    @(posedge clk_sys);
    {fuseWordValid, fuseLast} <= 2'h0;
    #1;
    if (!dbl) chk("cfgbyte", {configByteValid, configByte}, {1'h1, exp});
  endtask
  // Power-on reset and optional self-test
  task automatic boot(input logic atPor, input logic pass);
    @(posedge clk_sys);
    {rst, selfTestAtPowerup, hardFault, errCfg} <= {1'h1, atPor, 13'h0000};
    cyc(4);
    rst <= 1'h0;
    @(posedge clk_sys);
    #1;
    chk("uvmask", uvFaultMask, 1'h1);
    chk("state0", monitorStateRegister, atPor ? esm_ctrl_pkg::SELF_TEST : esm_ctrl_pkg::CFG_LOAD);
    chk("hostidle", {selfTestStart, hostPortEnable, interruptOutputN}, {atPor, !atPor, 1'h1});
    if (!atPor) return;
    @(posedge clk_sys);
    #1;
    chk("startpls", selfTestStart, 1'h0);
    @(posedge clk_sys);
    {selfTestDone, selfTestPass} <= {1'h1, pass};
    @(posedge clk_sys);
    selfTestDone <= 1'h0;
    #1;
    chk("done", {selfTestDoneFlag, selfTestDoneStatus, interruptOutputN, hostPortEnable}, 4'hD);
    hostPulse(1'h1, 1'h1, 1'h0);
  endtask
  task automatic up();
    boot(1'h1, 1'h1);
    fuse(enc(8'hA5), 1'h0, 8'hA5, 1'h0);
    fuse(enc(8'h3C) ^ 13'h0040, 1'h1, 8'h3C, 1'h0);
    waitState(esm_ctrl_pkg::ACTIVE);
    chk("rstrel", resetOutputN, 1'h1);
  endtask
  ////////////////////////////////////////
  // Every mapping against both enable levels
  task automatic testMapping();
    logic irqSeen, wdoSeen, rstSeen;
    up();
    chk("uvmask", uvFaultMask, 1'h0);
    for (int m = 0; m < 16; m++) begin
      @(posedge clk_sys);
      {errCfg, watchdogEnablePin, errorCmd} <= {m[2:0], 8'h00, m[3], 1'h1};
      {irqSeen, wdoSeen, rstSeen} = 3'h0;
      repeat (40) begin
        @(posedge clk_sys);
        #1;
        irqSeen |= !interruptOutputN;
        wdoSeen |= !watchdogFaultOutputN;
        rstSeen |= !resetOutputN;
      end
      chk("flag", errorSignalFaultFlag, 1'h1);
      chk("routes", {irqSeen, wdoSeen, rstSeen}, {m[1], m[2] & m[3], m[0]});
      chk("latched", interruptOutputN, !m[1]);
      @(posedge clk_sys);
      errorCmd <= 1'h0;
      cyc(4);
      hostPulse(1'h1, 1'h0, 1'h0);
      chk("clear", {errorSignalFaultFlag, interruptOutputN, watchdogFaultOutputN}, 3'h3);
    end
  endtask
  // Delay bands at their edges
  task automatic testDelay();
    int n, ms;
    logic [7:0] codes [6] = '{8'h00, 8'h1F, 8'h20, 8'h3F, 8'h40, 8'hFF};
    foreach (codes[k]) begin
      ms = codes[k] < 32 ? codes[k] + 1 : codes[k] < 64 ? 34 + 2 * (codes[k] - 32) : 100 + 4 * (codes[k] - 64);
      @(posedge clk_sys);
      {errCfg, errorCmd} <= {3'h2, codes[k], 1'h1};
      n = 0;
      while (errorSignalFaultFlag !== 1'h1 && n < 4000) begin
        @(posedge clk_sys);
        #1;
        n++;
      end
      chk("delay", n >= (ms - 1) * MS && n <= ms * MS + 4, 1'h1);
      if (n == 4000) stopTest();
      @(posedge clk_sys);
      errorCmd <= 1'h0;
      cyc(4);
      hostPulse(1'h1, 1'h0, 1'h0);
    end
  endtask
  // Stuck error into reset, ungated and gated by the watchdog output
  task automatic testResetPulse();
    int falls, len;
    for (int g = 0; g < 2; g++) begin
      @(posedge clk_sys);
      {errCfg, watchdogEnablePin, resetHoldDelay, stuckLow, errorCmd} <= {g[0], 10'h100, 1'h1, 8'h03, 2'h3};
      {falls, len} = 0;
      repeat (150) begin
        @(posedge clk_sys);
        #1;
        if (!resetOutputN) len++;
        else if (len > 0) begin
          chk("holdlen", len >= 3 * MS - 1 && len <= 3 * MS + 1, 1'h1);
          falls++;
          len = 0;
        end
      end
      chk("pulses", falls > 1, !g[0]);
      @(posedge clk_sys);
      {errorCmd, stuckLow} <= 2'h0;
      cyc(16);
      hostPulse(1'h1, 1'h0, 1'h0);
    end
  endtask
  // Double error in fuse load, then no way out
  task automatic testFailSafe();
    boot(1'h0, 1'h0);
    fuse(enc(8'h5A) ^ 13'h0028, 1'h1, 8'h00, 1'h1);
    waitState(esm_ctrl_pkg::LATCHED_FAULT_STATE);
    chk("ded", {doubleErrorDetect, resetOutputN, interruptOutputN}, 3'h4);
    hostPulse(1'h1, 1'h1, 1'h1);
    cyc(8);
    #1;
    chk("stuck", {monitorStateRegister, hostPortEnable}, {esm_ctrl_pkg::LATCHED_FAULT_STATE, 1'h1});
  endtask
  // Thermal, address-pin and self-test failures
  task automatic testFailures();
    for (int i = 0; i < 3; i++) begin
      up();
      if (i < 2) begin
        @(posedge clk_sys);
        hardFault <= 2'h1 << i;
      end else begin
        hostPulse(1'h0, 1'h0, 1'h1);
        waitState(esm_ctrl_pkg::SELF_TEST);
        @(posedge clk_sys);
        {selfTestDone, selfTestPass} <= 2'h2;
        @(posedge clk_sys);
        selfTestDone <= 1'h0;
        #1;
      end
      waitState(esm_ctrl_pkg::LATCHED_FAULT_STATE);
      chk("fsout", {resetOutputN, interruptOutputN}, 2'h0);
    end
  endtask
  initial begin
    testMapping();
    testDelay();
    testResetPulse();
    testFailSafe();
    testFailures();
    stopTest();
  end
endmodule
